// File: src/tsh_pkg.sv
// Constants and types for the thermometer bus controller.
// Assumes a 200 MHz core clock; all bus timing is derived from it.
package tsh_pkg;

	// Core clock and bus clock timing
	localparam int CORE_PERIOD_NS = 5;
	localparam int SCL_PERIOD_NS = 10000;
	localparam int QTR_CYC = SCL_PERIOD_NS / (4 * CORE_PERIOD_NS);

	// Fixed upper address bits and command codes
	localparam logic [3:0] DEV_ADDR_HI = 4'h9;
	localparam logic [7:0] SOFT_RESET_CMD = 8'h54;
	localparam logic [5:0] PTR_PAD = 6'h00;

	// Register selects carried in the two low pointer bits
	localparam logic [1:0] PTR_TEMP = 2'h0;
	localparam logic [1:0] PTR_CFG = 2'h1;
	localparam logic [1:0] PTR_HYST = 2'h2;
	localparam logic [1:0] PTR_OVT = 2'h3;

	// Bit slot holding the acknowledge
	localparam logic [3:0] ACK_SLOT = 4'h8;

	// Quarter phases of one bus clock period
	localparam logic [1:0] Q_SETUP = 2'h0;
	localparam logic [1:0] Q_RISE = 2'h1;
	localparam logic [1:0] Q_SAMPLE = 2'h2;
	localparam logic [1:0] Q_FALL = 2'h3;

	typedef enum logic [1:0] {OP_WRITE, OP_READ_CUR, OP_READ_PTR, OP_SOFT_RESET} tsh_op_e;
	typedef enum logic [2:0] {ROLE_ADDR_W, ROLE_PTR, ROLE_DATA, ROLE_CMD, ROLE_ADDR_R} tsh_role_e;
	typedef enum logic [2:0] {ST_IDLE, ST_START, ST_TX, ST_RX, ST_STOP, ST_DONE} tsh_state_e;

endpackage : tsh_pkg

// File: src/tsh_sync2.sv
// Two-stage synchroniser for one level.
// Assumes an active-low asynchronous reset in the destination domain.
`timescale 1ns/1ps
module tsh_sync2 #(
	parameter logic RST_VAL = 1'b0
) (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic d,
	output logic q
);
	logic stage1;

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			stage1 <= RST_VAL;
			q <= RST_VAL;
		end
		else
		begin
			stage1 <= d;
			q <= stage1;
		end
	end
endmodule : tsh_sync2

// File: src/tsh_host.sv
// Bus controller that drives the thermometer's two-wire target port.
// Assumes open-drain pads outside: an enable pulls the wire low, release lets it float high.
`timescale 1ns/1ps
module tsh_host
	import tsh_pkg::*;
#(
	parameter int QTR = QTR_CYC
) (
	// Clock and reset
	input wire logic CORE_CLK,
	input wire logic RESET_N,
	// Command
	input wire logic CMD_VALID,
	output logic CMD_READY,
	input wire logic [1:0] CMD_OP,
	input wire logic [1:0] CMD_PTR,
	input wire logic CMD_LEN2,
	input wire logic [15:0] CMD_WDATA,
	input wire logic [2:0] ADDR_SEL,
	// Response
	output logic RSP_VALID,
	output logic RSP_NACK,
	output logic [15:0] RSP_RDATA,
	output logic [1:0] PTR_CUR,
	// Bus pins
	output logic SCL_O,
	output logic SCL_OE,
	input wire logic SDA_I,
	output logic SDA_O,
	output logic SDA_OE
);
	logic rst_n;
	logic sda_s;
	tsh_state_e state, next_state;
	tsh_op_e op, next_op;
	tsh_role_e role, next_role;
	logic [15:0] div, next_div;
	logic [1:0] qtr, next_qtr;
	logic [3:0] bitn, next_bitn;
	logic [7:0] shreg, next_shreg;
	logic [6:0] addr, next_addr;
	logic [1:0] ptr, next_ptr;
	logic [1:0] ptr_cur, next_ptr_cur;
	logic [15:0] wdata, next_wdata;
	logic [15:0] rdata, next_rdata;
	logic [1:0] left, next_left;
	logic len2, next_len2;
	logic rd_phase, next_rd_phase;
	logic ack_n, next_ack_n;
	logic nack, next_nack;
	logic scl_low, next_scl_low;
	logic sda_low, next_sda_low;
	// Run length of the bus clock held low, for the hold-limit bound
	logic [15:0] scl_low_cnt, next_scl_low_cnt;
	logic tick;

	tsh_sync2 #(.RST_VAL(1'b0)) u_rst_sync (
		.clk(CORE_CLK),
		.arst_n(RESET_N),
		.d(1'b1),
		.q(rst_n)
	);

	// Pin input crosses in from the wire before any logic looks at it
	tsh_sync2 #(.RST_VAL(1'b1)) u_sda_sync (
		.clk(CORE_CLK),
		.arst_n(RESET_N),
		.d(SDA_I),
		.q(sda_s)
	);

	assign tick = (div == 16'(QTR - 1));
	assign CMD_READY = (state == ST_IDLE);
	assign RSP_VALID = (state == ST_DONE);
	assign RSP_NACK = nack;
	assign RSP_RDATA = rdata;
	assign PTR_CUR = ptr_cur;
	assign SCL_O = 1'b0;
	assign SCL_OE = scl_low;
	assign SDA_O = 1'b0;
	assign SDA_OE = sda_low;

	always_comb
	begin
		next_state = state;
		next_op = op;
		next_role = role;
		{next_qtr, next_bitn, next_shreg, next_addr} = {qtr, bitn, shreg, addr};
		{next_ptr, next_ptr_cur, next_wdata, next_rdata} = {ptr, ptr_cur, wdata, rdata};
		{next_left, next_len2, next_rd_phase, next_ack_n} = {left, len2, rd_phase, ack_n};
		{next_nack, next_scl_low, next_sda_low} = {nack, scl_low, sda_low};
		// A long clock-low stretch could let the target's data hold trip, so it is watched
		next_scl_low_cnt = scl_low ? scl_low_cnt + 16'h0001 : 16'h0000;
		// Divider makes the bus clock; quarters give clean setup and hold around edges
		next_div = (state == ST_IDLE || state == ST_DONE || tick) ? 16'h0000 : div + 16'h0001;
		if (tick)
			next_qtr = qtr + 2'h1;
		case (state)
			ST_IDLE:
			begin
				next_qtr = Q_SETUP;
				if (CMD_VALID)
				begin
					next_op = tsh_op_e'(CMD_OP);
					next_ptr = CMD_PTR;
					next_len2 = CMD_LEN2;
					next_wdata = CMD_WDATA;
					next_addr = {DEV_ADDR_HI, ADDR_SEL};
					next_rd_phase = (tsh_op_e'(CMD_OP) == OP_READ_CUR);
					next_left = CMD_LEN2 ? 2'h2 : 2'h1;
					next_nack = 1'b0;
					next_rdata = 16'h0000;
					next_state = ST_START;
				end
			end
			ST_START:
			begin
				// Also serves the repeated start, entered with the clock low
				if (tick)
				begin
					case (qtr)
						Q_SETUP: {next_scl_low, next_sda_low} = 2'h2;
						Q_RISE: next_scl_low = 1'b0;
						Q_SAMPLE: next_sda_low = 1'b1;
						default:
						begin
							next_scl_low = 1'b1;
							next_shreg = {addr, rd_phase};
							next_role = rd_phase ? ROLE_ADDR_R : ROLE_ADDR_W;
							next_bitn = 4'h0;
							next_state = ST_TX;
						end
					endcase
				end
			end
			ST_TX, ST_RX:
			begin
				if (tick)
				begin
					case (qtr)
						Q_SETUP:
						begin
							if (bitn < ACK_SLOT)
								next_sda_low = (state == ST_TX) ? ~shreg[7] : 1'b0;
							else
								next_sda_low = (state == ST_RX) && (left != 2'h1);
						end
						Q_RISE: next_scl_low = 1'b0;
						Q_SAMPLE:
						begin
							if (bitn < ACK_SLOT && state == ST_RX)
								next_shreg = {shreg[6:0], sda_s};
							if (bitn == ACK_SLOT && state == ST_TX)
								next_ack_n = sda_s;
						end
						default:
						begin
							next_scl_low = 1'b1;
							next_bitn = 4'h0;
							if (bitn < ACK_SLOT)
							begin
								next_bitn = bitn + 4'h1;
								if (state == ST_TX)
									next_shreg = {shreg[6:0], 1'b0};
							end
							else if (state == ST_RX)
							begin
								next_left = left - 2'h1;
								if (!len2 || left == 2'h2)
									next_rdata = {shreg, 8'h00};
								else
									next_rdata = {rdata[15:8], shreg};
								if (left == 2'h1)
									next_state = ST_STOP;
							end
							else if (role == ROLE_CMD)
							begin
								// No acknowledge is expected for this byte
								next_ptr_cur = PTR_TEMP;
								next_state = ST_STOP;
							end
							else if (ack_n)
							begin
								next_nack = 1'b1;
								next_state = ST_STOP;
							end
							else
							begin
								case (role)
									ROLE_ADDR_W:
									begin
										if (op == OP_SOFT_RESET)
										begin
											next_shreg = SOFT_RESET_CMD;
											next_role = ROLE_CMD;
										end
										else
										begin
											next_shreg = {PTR_PAD, ptr};
											next_role = ROLE_PTR;
										end
									end
									ROLE_PTR:
									begin
										next_ptr_cur = ptr;
										if (op == OP_WRITE)
										begin
											next_shreg = wdata[15:8];
											next_role = ROLE_DATA;
										end
										else
										begin
											next_rd_phase = 1'b1;
											next_state = ST_START;
										end
									end
									ROLE_DATA:
									begin
										next_left = left - 2'h1;
										next_shreg = wdata[7:0];
										if (left == 2'h1)
											next_state = ST_STOP;
									end
									ROLE_ADDR_R: next_state = ST_RX;
									default: next_state = ST_STOP;
								endcase
							end
						end
					endcase
				end
			end
			ST_STOP:
			begin
				if (tick)
				begin
					case (qtr)
						Q_SETUP: {next_scl_low, next_sda_low} = 2'h3;
						Q_RISE: next_scl_low = 1'b0;
						Q_SAMPLE: next_sda_low = 1'b0;
						default: next_state = ST_DONE;
					endcase
				end
			end
			ST_DONE: next_state = ST_IDLE;
			default: next_state = ST_IDLE;
		endcase
	end

	always_ff @(posedge CORE_CLK or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state <= ST_IDLE;
			op <= OP_WRITE;
			role <= ROLE_ADDR_W;
			{div, qtr, bitn, shreg, addr} <= {16'h0000, Q_SETUP, 4'h0, 8'h00, 7'h00};
			{ptr, ptr_cur, wdata, rdata} <= {PTR_TEMP, PTR_TEMP, 16'h0000, 16'h0000};
			{left, len2, rd_phase, ack_n} <= {2'h0, 1'b0, 1'b0, 1'b1};
			{nack, scl_low, sda_low, scl_low_cnt} <= {1'b0, 1'b0, 1'b0, 16'h0000};
		end
		else
		begin
			state <= next_state;
			op <= next_op;
			role <= next_role;
			{div, qtr, bitn, shreg, addr} <= {next_div, next_qtr, next_bitn, next_shreg, next_addr};
			{ptr, ptr_cur, wdata, rdata} <= {next_ptr, next_ptr_cur, next_wdata, next_rdata};
			{left, len2, rd_phase, ack_n} <= {next_left, next_len2, next_rd_phase, next_ack_n};
			{nack, scl_low, sda_low} <= {next_nack, next_scl_low, next_sda_low};
			scl_low_cnt <= next_scl_low_cnt;
		end
	end

	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (!rst_n);

	sequence s_stop_edge;
		state == ST_STOP && tick && qtr == Q_FALL;
	endsequence
	sequence s_return_idle;
		(state == ST_DONE) ##1 (state == ST_IDLE);
	endsequence
	sequence s_start_load;
		state == ST_START && tick && qtr == Q_FALL;
	endsequence

	a_msb_first_out: assert property ((state == ST_TX) && bitn < ACK_SLOT && qtr == Q_SAMPLE
		|-> sda_low == ~shreg[7]) else $error("data bit out of order");
	a_sda_stable_high: assert property ((state == ST_TX || state == ST_RX) && !scl_low
		|=> scl_low || $stable(sda_low)) else $error("data moved while clock high");
	a_open_with_start: assert property (state == ST_IDLE && CMD_VALID
		|=> state == ST_START && !sda_low) else $error("frame not opened by start");
	a_nine_slots: assert property ((state == ST_TX || state == ST_RX)
		|-> bitn <= ACK_SLOT) else $error("more than nine slots");
	a_addr_direction: assert property (s_start_load
		|=> shreg == {DEV_ADDR_HI, ADDR_SEL, rd_phase}) else $error("bad address byte");
	a_ptr_upper_zero: assert property ((state == ST_TX) && role == ROLE_PTR && bitn == 4'h0
		|-> shreg[7:2] == PTR_PAD) else $error("pointer upper bits set");
	a_master_ack_last: assert property ((state == ST_RX) && bitn == ACK_SLOT && !scl_low
		|-> sda_low == (left != 2'h1)) else $error("wrong controller acknowledge");
	a_stop_then_idle: assert property (s_stop_edge |=> s_return_idle)
		else $error("stop did not end frame");
	a_soft_cmd_byte: assert property ((state == ST_TX) && role == ROLE_CMD && bitn == 4'h0
		|-> shreg == SOFT_RESET_CMD && op == OP_SOFT_RESET) else $error("bad reset byte");
	a_clock_low_bound: assert property (scl_low_cnt <= 16'(2 * QTR + 2))
		else $error("bus clock held low too long");
endmodule : tsh_host

// File: sim/tsh_tgt.sv
// Behavioural thermometer target on the two-wire bus, far side of the controller.
// Assumes open-drain wires built in the bench; oe high pulls the data line low.
`timescale 1ns/1ps
module tsh_tgt
	import tsh_pkg::*;
#(
	parameter logic [15:0] TEMP_INIT = 16'h1930,
	parameter int HOLD_NS = 100000
) (
	// Bus wires
	input wire logic scl,
	input wire logic sda,
	input wire logic [2:0] asel,
	// Data line pull-down
	output logic oe
);
	logic [15:0] regs [4];
	logic [7:0] sh;
	logic [7:0] tx;
	logic [1:0] ptr = 2'h0;
	logic act = 1'b0;
	logic rd = 1'b0;
	logic match = 1'b0;
	logic mack = 1'b0;
	logic nx = 1'b0;
	int cnt = 0;
	int role = 0;
	time t_low = 0;
	initial oe = 1'b0;
	initial foreach (regs[i]) regs[i] = (i == 0) ? TEMP_INIT : 16'h0000;
	always @(negedge sda) if (scl === 1'b1)
	begin
		act = 1'b1;
		cnt = 0;
		role = 0;
		rd = 1'b0;
		match = 1'b0;
	end
	always @(posedge sda) if (scl === 1'b1)
	begin
		act = 1'b0;
		oe = 1'b0;
	end
	always @(posedge scl) if (act)
	begin
		if (cnt < 8)
			sh = {sh[6:0], sda};
		else
			mack = ~sda;
		cnt = cnt + 1;
	end
	// Apart from the hold-limit release, drive changes only on the falling clock, so data is stable while it is high
	always @(negedge scl) if (act)
	begin
		nx = 1'b0;
		if (cnt == 8 && (role == 0 || !rd))
		begin
			if (role == 0)
			begin
				match = (sh[7:1] == {DEV_ADDR_HI, asel});
				rd = sh[0];
				nx = match;
			end
			else if (role == 1 && sh == SOFT_RESET_CMD)
			begin
				ptr = 2'h0;
				foreach (regs[i]) regs[i] = (i == 0) ? TEMP_INIT : 16'h0000;
				act = 1'b0;
			end
			else if (role == 1 && !rd)
			begin
				ptr = sh[1:0];
				nx = 1'b1;
			end
			else
			begin
				if (role == 2)
					regs[ptr][15:8] = sh;
				else
					regs[ptr][7:0] = sh;
				nx = 1'b1;
			end
		end
		if (cnt == 9)
		begin
			cnt = 0;
			role = role + 1;
			if (!match)
				act = 1'b0;
			else if (rd && (role == 1 || mack))
				tx = (role == 1) ? regs[ptr][15:8] : regs[ptr][7:0];
			else if (rd)
				act = 1'b0;
		end
		if (act && rd && role > 0 && cnt < 8)
			nx = ~tx[7 - cnt];
		// One update per edge, so the hold timer restarts only on a real fall of the line
		oe = nx;
	end
	always @(posedge oe) t_low = $time;
	always #50 if (oe && ($time - t_low >= HOLD_NS))
	begin
		oe = 1'b0;
		act = 1'b0;
	end
endmodule : tsh_tgt

// File: sim/testbench.sv
// Self-checking bench: controller against the behavioural target.
// Assumes pull-ups on both wires; expected responses are queued by the driver.
`timescale 1ns/1ps
module testbench;
	import tsh_pkg::*;
	typedef struct {logic nack; logic chk; logic [15:0] data; logic [1:0] ptr;} tsh_exp_s;
	// Short quarter keeps the target far below its hold limit
	localparam int QTR = 4;
	localparam logic [15:0] TEMP_VAL = 16'h1930;
	localparam logic [2:0] ASEL = 3'h5;
	logic core_clk = 1'b0;
	logic rst_n = 1'b0;
	logic cmd_valid = 1'b0;
	logic [1:0] cmd_op = 2'h0;
	logic [1:0] cmd_ptr = 2'h0;
	logic cmd_len2 = 1'b0;
	logic [15:0] cmd_wdata = 16'h0000;
	logic [2:0] addr_sel = ASEL;
	logic cmd_ready, rsp_valid, rsp_nack, scl_o, scl_oe, sda_o, sda_oe, tgt_oe;
	logic [15:0] rsp_rdata;
	logic [1:0] ptr_cur;
	// Pull-ups on both wires; an enabled driver shows its output level
	wire logic scl = scl_oe ? scl_o : 1'b1;
	wire logic sda = (sda_oe ? sda_o : 1'b1) & ~tgt_oe;
	tsh_exp_s exp_q [$];
	tsh_exp_s e;
	int n_mismatch = 0;
	int n_checks = 0;
	int cycles = 0;
	int seed = 89;
	logic [15:0] wd;
	logic len2;
	always #2.5 core_clk = ~core_clk;
	tsh_host #(.QTR(QTR)) tsh_host_inst (.CORE_CLK(core_clk), .RESET_N(rst_n),
		.CMD_VALID(cmd_valid), .CMD_READY(cmd_ready), .CMD_OP(cmd_op), .CMD_PTR(cmd_ptr),
		.CMD_LEN2(cmd_len2), .CMD_WDATA(cmd_wdata), .ADDR_SEL(addr_sel),
		.RSP_VALID(rsp_valid), .RSP_NACK(rsp_nack), .RSP_RDATA(rsp_rdata), .PTR_CUR(ptr_cur),
		.SCL_O(scl_o), .SCL_OE(scl_oe), .SDA_I(sda), .SDA_O(sda_o), .SDA_OE(sda_oe));
	tsh_tgt #(.TEMP_INIT(TEMP_VAL)) tsh_tgt_inst (.scl(scl), .sda(sda), .asel(ASEL),
		.oe(tgt_oe));
	task automatic results();
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : results
	task automatic fail(input string m);
		n_mismatch++;
		$display("[FAIL] %0t %s", $time, m);
	endtask : fail
	task automatic run(input logic [1:0] op, input logic [1:0] p, input logic l2,
		input logic [15:0] w, input logic [2:0] a, input tsh_exp_s x);
		exp_q.push_back(x);
		while (cmd_ready !== 1'b1)
			@(posedge core_clk);
		cmd_valid <= 1'b1;
		cmd_op <= op;
		cmd_ptr <= p;
		cmd_len2 <= l2;
		cmd_wdata <= w;
		addr_sel <= a;
		@(posedge core_clk);
		cmd_valid <= 1'b0;
		do @(posedge core_clk); while (rsp_valid !== 1'b1);
		repeat (3) @(posedge core_clk);
		$display("test op %0d ptr %0d done", op, p);
	endtask : run
	always @(posedge core_clk) if (rsp_valid === 1'b1)
	begin
		if (exp_q.size() == 0)
			fail("unexpected response");
		else
		begin
			e = exp_q.pop_front();
			n_checks++;
			if (rsp_nack !== e.nack || (e.chk && rsp_rdata !== e.data))
				fail("response mismatch");
			@(posedge core_clk);
			n_checks++;
			if (ptr_cur !== e.ptr)
				fail("pointer view mismatch");
		end
	end
	always @(posedge core_clk)
	begin
		cycles++;
		if (cycles == 30000)
		begin
			fail("timeout");
			results();
		end
	end
	initial
	begin
		repeat (6) @(posedge core_clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge core_clk);
		run(OP_READ_CUR, PTR_TEMP, 1'b1, 16'h0, ASEL, '{1'b0, 1'b1, TEMP_VAL, PTR_TEMP});
		for (int p = 1; p < 4; p++)
		begin
			wd = 16'($random(seed));
			len2 = (p != 1);
			run(OP_WRITE, p[1:0], len2, wd, ASEL, '{1'b0, 1'b0, 16'h0, p[1:0]});
			run(OP_READ_PTR, p[1:0], len2, 16'h0, ASEL,
				'{1'b0, 1'b1, len2 ? wd : {wd[15:8], 8'h00}, p[1:0]});
		end
		run(OP_READ_CUR, PTR_OVT, 1'b0, 16'h0, ASEL, '{1'b0, 1'b1, {wd[15:8], 8'h00}, PTR_OVT});
		run(OP_READ_CUR, PTR_TEMP, 1'b1, 16'h0, ASEL ^ 3'h2, '{1'b1, 1'b0, 16'h0, PTR_OVT});
		run(OP_READ_CUR, PTR_OVT, 1'b1, 16'h0, ASEL, '{1'b0, 1'b1, wd, PTR_OVT});
		run(OP_SOFT_RESET, PTR_TEMP, 1'b0, 16'h0, ASEL, '{1'b0, 1'b0, 16'h0, PTR_TEMP});
		run(OP_READ_CUR, PTR_TEMP, 1'b1, 16'h0, ASEL, '{1'b0, 1'b1, TEMP_VAL, PTR_TEMP});
		run(OP_READ_PTR, PTR_HYST, 1'b1, 16'h0, ASEL, '{1'b0, 1'b1, 16'h0, PTR_HYST});
		results();
	end
endmodule : testbench
